// [verification/hls_link_model.sv]
// hls_link_model: behavioural frame engine feeding events and line levels to the status bank
// assumes the bench calls its tasks from one process; every change lands just after aclk rises
`timescale 1ns/10ps
module hls_link_model (
  // clock
  input  wire logic            aclk,
  // from the status bank
  input  wire logic            send_not_ready,
  // to the status bank
  output hls_pkg::hls_events_s ev,
  output logic                 info_phase,
  output logic                 link_up,
  output logic                 tx_attempt,
  output logic                 serial_in,
  output logic [7:0]           error_cause
);
  // ==========================================================================
  // state
  hls_pkg::hls_events_s ev_q;
  logic [2:0]           tick_q;
  logic                 nr_q;

  initial begin
    ev_q        = '0;
    tick_q      = 3'h0;
    nr_q        = 1'b0;
    info_phase  = 1'b0;
    link_up     = 1'b0;
    tx_attempt  = 1'b0;
    serial_in   = 1'b0;
    error_cause = 8'h00;
  end

  // ==========================================================================
  // not-ready frames go out every eight cycles while the host is busy
  always @(posedge aclk) begin
    tick_q <= tick_q + 3'h1;
    nr_q   <= send_not_ready && (tick_q == 3'h7);
  end

  always_comb begin
    ev              = ev_q;
    ev.not_ready_tx = ev_q.not_ready_tx | nr_q;
  end

  // ==========================================================================
  // bench hooks; fire leaves settle time so flags and irq have landed on return
  task automatic fire(input hls_pkg::hls_events_s e);
    @(posedge aclk);
    ev_q <= e;
    @(posedge aclk);
    ev_q <= '0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic lv(input logic info, input logic up, input logic att, input logic [7:0] c);
    @(posedge aclk);
    info_phase  <= info;
    link_up     <= up;
    tx_attempt  <= att;
    error_cause <= c;
  endtask

  task automatic ser(input logic v);
    @(posedge aclk);
    serial_in <= v;
  endtask
endmodule

// [verification/hls_link_status_tb.sv]
// hls_link_status_tb: register-level test of the link status flag bank
// assumes hls_link_model stands in for the frame engine; the bench is the axi4-lite host
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module hls_link_status_tb;
  // ==========================================================================
  // signals
  logic                 aclk, aresetn;
  logic [3:0]           awaddr, araddr, wstrb;
  logic                 awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]          wdata, rdata, d;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [1:0]           bresp, rresp, resp;
  hls_pkg::hls_events_s ev;
  logic                 info_phase, link_up, tx_attempt, serial_in;
  logic [7:0]           error_cause, mask, cause_q, mask_seen;
  logic                 send_not_ready, send_reject, accept_frame, internal_rts, irq_n;
  int                   n_errors, checked, cyc, acc_cnt, rej_cnt;

  always #10 aclk = ~aclk;

  hls_link_status hls_link_status_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ev(ev), .info_phase(info_phase), .link_up(link_up), .tx_attempt(tx_attempt),
    .serial_in(serial_in), .error_cause(error_cause), .send_not_ready(send_not_ready),
    .send_reject(send_reject), .accept_frame(accept_frame), .segment_acked_mask(mask),
    .error_cause_register(cause_q), .internal_rts(internal_rts), .irq_n(irq_n));

  hls_link_model hls_link_model_inst (
    .aclk(aclk), .send_not_ready(send_not_ready), .ev(ev), .info_phase(info_phase),
    .link_up(link_up), .tx_attempt(tx_attempt), .serial_in(serial_in),
    .error_cause(error_cause));

  // ==========================================================================
  // pulse outputs last one cycle, so they are gathered here
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn && accept_frame === 1'b1) acc_cnt <= acc_cnt + 1;
    if (aresetn && send_reject === 1'b1) rej_cnt <= rej_cnt + 1;
    if (aresetn && mask !== 8'h00) mask_seen <= mask_seen | mask;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // axi4-lite master; ready is sampled mid-cycle, so the handshake edge is known
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, v};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      if (awready) da = 1'b1;
      if (wready) dw = 1'b1;
      @(posedge aclk);
      if (da) awvalid <= 1'b0;
      if (dw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d    = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // one event code per kind of link event other than not_ready_tx, which the model raises itself
  task automatic go(input int k);
    hls_pkg::hls_events_s e;
    e = '0;
    e.acked_count = 3'h2;
    case (k)
      0: e.addr_match = 1'b1;
      2: e.acked = 1'b1;
      3: e.fatal_error = 1'b1;
      4: e.link_change = 1'b1;
      5: e.chain_next = 1'b1;
      6: e.dir_reset = 1'b1;
      7: e.addr_wrong = 1'b1;
      8: e.timer_expired = 1'b1;
      9: e.timer_restart = 1'b1;
      10: e.tx_advance = 1'b1;
      default: e.acked_count = 3'h2;
    endcase
    e.packet_ok = (k < 2);
    hls_link_model_inst.fire(e);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {n_errors, checked, cyc, acc_cnt, rej_cnt} = '0;
    mask_seen = 8'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("send_not_ready", 1'b1, send_not_ready)
    rd(hls_pkg::LINK_CTRL_ADDR);
    `CHK("control", hls_pkg::CTRL_RESET, d)
    rd(hls_pkg::LINE_STATUS_ADDR);
    `CHK("line", 8'h01, d)
    rd(hls_pkg::EVENT_STATUS_ADDR);
    `CHK("event", 8'h00, d)
    repeat (10) @(negedge aclk);
    rd(hls_pkg::SEQ_STATUS_ADDR);
    `CHK("seq", 8'h01, d)
    wr(hls_pkg::LINK_CTRL_ADDR, 8'h01);
    `CHK("bresp", hls_pkg::RESP_OKAY, resp)
    repeat (12) @(negedge aclk);
    `CHK("send_not_ready", 1'b0, send_not_ready)
    wr(hls_pkg::SEQ_STATUS_ADDR, 8'hFF);
    `CHK("bresp", hls_pkg::RESP_OKAY, resp)
    rd(hls_pkg::SEQ_STATUS_ADDR);
    `CHK("seq", 8'h00, d)
    `CHK("rresp", hls_pkg::RESP_OKAY, resp)
    wr(4'h2, 8'h01);
    `CHK("bresp", hls_pkg::RESP_SLVERR, resp)
    rd(4'h2);
    `CHK("unmapped", 8'h00, d)
    `CHK("rresp", hls_pkg::RESP_SLVERR, resp)
    rd(hls_pkg::LINK_CTRL_ADDR);
    `CHK("control", 8'h01, d)
    repeat (3) go(10);
    rd(hls_pkg::SEQ_STATUS_ADDR);
    `CHK("seq", 8'h06, d)
    go(2);
    `CHK("acked mask", 8'h06, mask_seen)
    `CHK("irq_n", 1'b0, irq_n)
    rd(hls_pkg::EVENT_STATUS_ADDR);
    `CHK("event", 8'h40, d)
    @(negedge aclk);
    `CHK("irq_n", 1'b1, irq_n)
    hls_link_model_inst.lv(1'b0, 1'b0, 1'b0, 8'h5A);
    go(0);
    `CHK("irq_n", 1'b0, irq_n)
    go(3);
    `CHK("irq_n", 1'b0, irq_n)
    `CHK("error cause", 8'h5A, cause_q)
    `CHK("accepted", 1, acc_cnt)
    rd(hls_pkg::EVENT_STATUS_ADDR);
    `CHK("event", 8'hA2, d)
    rd(hls_pkg::EVENT_STATUS_ADDR);
    `CHK("event", 8'h02, d)
    for (int k = 4; k < 7; k++) begin
      go(k);
      rd(hls_pkg::EVENT_STATUS_ADDR);
      `CHK("event", 8'h22, d)
    end
    go(1);
    `CHK("accepted", 1, acc_cnt)
    rd(hls_pkg::EVENT_STATUS_ADDR);
    `CHK("event", 8'h02, d)
    hls_link_model_inst.lv(1'b1, 1'b0, 1'b0, 8'h5A);
    go(7);
    `CHK("rejects", 1, rej_cnt)
    rd(hls_pkg::LINE_STATUS_ADDR);
    `CHK("line", 8'h03, d)
    hls_link_model_inst.lv(1'b0, 1'b0, 1'b0, 8'h5A);
    go(7);
    `CHK("rejects", 1, rej_cnt)
    go(8);
    rd(hls_pkg::LINE_STATUS_ADDR);
    `CHK("line", 8'h83, d)
    go(9);
    rd(hls_pkg::LINE_STATUS_ADDR);
    `CHK("line", 8'h03, d)
    hls_link_model_inst.lv(1'b0, 1'b1, 1'b1, 8'h5A);
    repeat (3) @(negedge aclk);
    `CHK("internal_rts", 1'b1, internal_rts)
    rd(hls_pkg::LINE_STATUS_ADDR);
    `CHK("line", 8'h42, d)
    // fourteen ones fall one short of idle
    hls_link_model_inst.ser(1'b1);
    repeat (13) @(posedge aclk);
    hls_link_model_inst.ser(1'b0);
    repeat (6) @(negedge aclk);
    rd(hls_pkg::LINE_STATUS_ADDR);
    `CHK("line", 8'h42, d)
    hls_link_model_inst.ser(1'b1);
    repeat (25) @(posedge aclk);
    rd(hls_pkg::LINE_STATUS_ADDR);
    `CHK("line", 8'h62, d)
    hls_link_model_inst.ser(1'b0);
    repeat (8) @(negedge aclk);
    rd(hls_pkg::LINE_STATUS_ADDR);
    `CHK("line", 8'h42, d)
    complete_run();
  end
endmodule

// [verilog/hls_link_status.sv]
// hls_link_status: status flag bank of an x.25 link-level controller with an axi4-lite slave
// assumes events arrive as one-cycle pulses on aclk; serial line input comes from a pin
`timescale 1ns/10ps
module hls_link_status #(
  parameter int IDLE_ONES = hls_pkg::IDLE_ONES_MIN
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write
  input  wire logic [3:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // link engine
  input  wire hls_pkg::hls_events_s ev,
  input  wire logic                info_phase,
  input  wire logic                link_up,
  input  wire logic                tx_attempt,
  input  wire logic                serial_in,
  input  wire logic [7:0]          error_cause,
  // link engine commands
  output logic                     send_not_ready,
  output logic                     send_reject,
  output logic                     accept_frame,
  output logic [7:0]               segment_acked_mask,
  output logic [7:0]               error_cause_register,
  output logic                     internal_rts,
  output logic                     irq_n
);

  // ==========================================================================
  // serial input synchroniser: change counts once stages two and three agree
  logic [2:0] sin_q;
  logic       sin_stable_q;
  logic       sin_stable_d;
  always_comb begin
    sin_stable_d = (sin_q[1] == sin_q[2]) ? sin_q[2] : sin_stable_q;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sin_q        <= 3'h0;
      sin_stable_q <= 1'b0;
    end else begin
      sin_q        <= {sin_q[1:0], serial_in};
      sin_stable_q <= sin_stable_d;
    end
  end

  // ==========================================================================
  // status state
  logic [2:0] next_tx_block_q, next_tx_block_d, next_expected_segment_q, next_expected_segment_d;
  logic       not_ready_sent_q, not_ready_sent_d, packet_received_flag_q, packet_received_flag_d;
  logic       blocks_acked_flag_q, blocks_acked_flag_d, error_flag_q, error_flag_d;
  logic       retry_timer_expired_q, retry_timer_expired_d, rx_idle_q, rx_idle_d;
  logic       wrong_address_flag_q, wrong_address_flag_d, host_rx_ready_q, host_rx_ready_d;
  logic       irq_n_q, irq_n_d, send_reject_q, send_reject_d, accept_q, accept_d;
  logic [4:0] ones_cnt_q, ones_cnt_d;
  logic [7:0] ack_mask_q, ack_mask_d, err_cause_q, err_cause_d, ctl_wdata;
  logic       rts_q, ev_clear, ctl_write;

  // hardware set beats the read clear, so no event is lost in the clear cycle
  always_comb begin
    next_expected_segment_d = next_expected_segment_q;
    packet_received_flag_d  = packet_received_flag_q;
    blocks_acked_flag_d     = blocks_acked_flag_q;
    error_flag_d            = error_flag_q;
    retry_timer_expired_d   = retry_timer_expired_q;
    wrong_address_flag_d    = wrong_address_flag_q;
    ones_cnt_d              = ones_cnt_q;
    rx_idle_d               = rx_idle_q;
    send_reject_d           = 1'b0;
    accept_d                = 1'b0;
    ack_mask_d              = 8'h00;
    err_cause_d             = err_cause_q;
    next_tx_block_d  = ev.tx_advance ? next_tx_block_q + 3'h1 : next_tx_block_q;
    host_rx_ready_d  = ctl_write ? ctl_wdata[hls_pkg::CTL_RX_READY] : host_rx_ready_q;
    not_ready_sent_d = !host_rx_ready_q && (not_ready_sent_q || ev.not_ready_tx);
    if (ev_clear) begin
      packet_received_flag_d = 1'b0;
      blocks_acked_flag_d    = 1'b0;
      error_flag_d           = 1'b0;
    end
    if (ev.packet_ok && ev.addr_match) begin
      packet_received_flag_d  = 1'b1;
      next_expected_segment_d = next_expected_segment_q + 3'h1;
      accept_d                = 1'b1;
    end
    if (ev.acked) begin
      blocks_acked_flag_d = 1'b1;
      for (int i = 0; i < 8; i++) begin
        if (3'(i) < ev.acked_count) begin
          ack_mask_d[3'(next_tx_block_q - ev.acked_count + 3'(i))] = 1'b1;
        end
      end
    end
    if (ev.fatal_error || ev.link_change || ev.chain_next || ev.dir_reset) begin
      error_flag_d = 1'b1;
      err_cause_d  = error_cause;
    end
    if (ev.timer_restart) begin
      retry_timer_expired_d = 1'b0;
    end else if (ev.timer_expired) begin
      retry_timer_expired_d = 1'b1;
    end
    if (ev.addr_wrong) begin
      wrong_address_flag_d = 1'b1;
      send_reject_d        = info_phase;
    end else if (ev.addr_match) begin
      wrong_address_flag_d = 1'b0;
    end
    if (!sin_stable_q) begin
      ones_cnt_d = 5'h00;
      rx_idle_d  = 1'b0;
    end else if (ones_cnt_q < 5'(IDLE_ONES)) begin
      ones_cnt_d = ones_cnt_q + 5'h01;
      rx_idle_d  = (ones_cnt_q == 5'(IDLE_ONES - 1));
    end
    // interrupt follows the three cause flags so it holds until the read clears them
    irq_n_d = !(packet_received_flag_d || blocks_acked_flag_d || error_flag_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_tx_block_q         <= 3'h0;
      next_expected_segment_q <= 3'h0;
      not_ready_sent_q        <= 1'b0;
      packet_received_flag_q  <= 1'b0;
      blocks_acked_flag_q     <= 1'b0;
      error_flag_q            <= 1'b0;
      retry_timer_expired_q   <= 1'b0;
      wrong_address_flag_q    <= 1'b0;
      ones_cnt_q              <= 5'h00;
      rx_idle_q               <= 1'b0;
      host_rx_ready_q         <= 1'b0;
      irq_n_q                 <= 1'b1;
      send_reject_q           <= 1'b0;
      accept_q                <= 1'b0;
      ack_mask_q              <= 8'h00;
      err_cause_q             <= 8'h00;
      rts_q                   <= 1'b0;
    end else begin
      next_tx_block_q         <= next_tx_block_d;
      next_expected_segment_q <= next_expected_segment_d;
      not_ready_sent_q        <= not_ready_sent_d;
      packet_received_flag_q  <= packet_received_flag_d;
      blocks_acked_flag_q     <= blocks_acked_flag_d;
      error_flag_q            <= error_flag_d;
      retry_timer_expired_q   <= retry_timer_expired_d;
      wrong_address_flag_q    <= wrong_address_flag_d;
      ones_cnt_q              <= ones_cnt_d;
      rx_idle_q               <= rx_idle_d;
      host_rx_ready_q         <= host_rx_ready_d;
      irq_n_q                 <= irq_n_d;
      send_reject_q           <= send_reject_d;
      accept_q                <= accept_d;
      ack_mask_q              <= ack_mask_d;
      err_cause_q             <= err_cause_d;
      rts_q                   <= tx_attempt;
    end
  end

  assign send_not_ready       = ~host_rx_ready_q;
  assign send_reject          = send_reject_q;
  assign accept_frame         = accept_q;
  assign segment_acked_mask   = ack_mask_q;
  assign error_cause_register = err_cause_q;
  assign internal_rts         = rts_q;
  assign irq_n                = irq_n_q;

  // ==========================================================================
  // axi4-lite write: address and data taken in either order or in the same cycle, one write at a time
  logic       aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic [3:0] aw_addr_q, aw_addr_d;
  logic [7:0] w_data_q, w_data_d;
  logic       w_lane_q, w_lane_d;
  logic [1:0] bresp_q, bresp_d;
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    ctl_write = 1'b0;
    ctl_wdata = w_data_q;
    if (s_axi_awvalid && !aw_have_q && !bvalid_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_q && !bvalid_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
    end
    if (aw_have_q && w_have_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = hls_pkg::RESP_OKAY;
      if (aw_addr_q == hls_pkg::LINK_CTRL_ADDR) begin
        ctl_write = w_lane_q;
      end else if (aw_addr_q[1:0] != 2'h0) begin // every aligned word is mapped
        bresp_d = hls_pkg::RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= hls_pkg::CTRL_RESET;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= hls_pkg::RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q  <= w_data_d;
      w_lane_q  <= w_lane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ==========================================================================
  // axi4-lite read: snapshot taken at address handshake, event flags cleared then
  hls_pkg::hls_rd_e rd_st_q, rd_st_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  always_comb begin
    rd_st_d  = rd_st_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    ev_clear = 1'b0;
    case (rd_st_q)
      hls_pkg::HLS_RD_IDLE: begin
        if (s_axi_arvalid) begin
          rd_st_d = hls_pkg::HLS_RD_RESP;
          rresp_d = hls_pkg::RESP_OKAY;
          case (s_axi_araddr)
            hls_pkg::SEQ_STATUS_ADDR: rdata_d = {4'h0, next_tx_block_q, not_ready_sent_q};
            hls_pkg::EVENT_STATUS_ADDR: begin
              rdata_d  = {packet_received_flag_q, blocks_acked_flag_q, error_flag_q,
                          1'b0, next_expected_segment_q, 1'b0};
              ev_clear = 1'b1;
            end
            hls_pkg::LINE_STATUS_ADDR:
              rdata_d = {retry_timer_expired_q, rts_q, rx_idle_q, 3'h0,
                         wrong_address_flag_q, !link_up};
            hls_pkg::LINK_CTRL_ADDR: rdata_d = {7'h00, host_rx_ready_q};
            default: begin
              rdata_d = 8'h00;
              rresp_d = hls_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      hls_pkg::HLS_RD_RESP: rd_st_d = s_axi_rready ? hls_pkg::HLS_RD_IDLE : rd_st_q;
      default: rd_st_d = hls_pkg::HLS_RD_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_q <= hls_pkg::HLS_RD_IDLE;
      rdata_q <= 8'h00;
      rresp_q <= hls_pkg::RESP_OKAY;
    end else begin
      rd_st_q <= rd_st_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
  assign s_axi_arready = (rd_st_q == hls_pkg::HLS_RD_IDLE);
  assign s_axi_rvalid  = (rd_st_q == hls_pkg::HLS_RD_RESP);
  assign s_axi_rdata   = {24'h000000, rdata_q};
  assign s_axi_rresp   = rresp_q;

  // ==========================================================================
  // checks
  property p_irq_low;
    @(posedge aclk) disable iff (!aresetn) (ev.packet_ok && ev.addr_match) |=> !irq_n;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq not low after packet");
  property p_irq_matches;
    @(posedge aclk) disable iff (!aresetn)
      irq_n == !(packet_received_flag_q || blocks_acked_flag_q || error_flag_q);
  endproperty
  a_irq_matches: assert property (p_irq_matches) else $error("irq differs from flags");
  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
      (ev_clear && !ev.packet_ok && !ev.acked && !ev.fatal_error && !ev.link_change
       && !ev.chain_next && !ev.dir_reset) |=> irq_n;
  endproperty
  a_clear: assert property (p_clear) else $error("read did not release irq");
  property p_ne_adv;
    @(posedge aclk) disable iff (!aresetn)
      (ev.packet_ok && ev.addr_match) |=>
        next_expected_segment_q == $past(next_expected_segment_q) + 3'h1;
  endproperty
  a_ne_adv: assert property (p_ne_adv) else $error("segment not advanced");
  property p_timeout;
    @(posedge aclk) disable iff (!aresetn) ev.timer_restart |=> !retry_timer_expired_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not cleared");
  property p_reject;
    @(posedge aclk) disable iff (!aresetn) (ev.addr_wrong && info_phase) |=> send_reject;
  endproperty
  a_reject: assert property (p_reject) else $error("no reject sent");
  property p_idle;
    @(posedge aclk) disable iff (!aresetn) rx_idle_q |-> ones_cnt_q == 5'(IDLE_ONES);
  endproperty
  a_idle: assert property (p_idle) else $error("idle too early");
  property p_acked;
    @(posedge aclk) disable iff (!aresetn) ev.acked |=> blocks_acked_flag_q && !irq_n;
  endproperty
  a_acked: assert property (p_acked) else $error("ack flag missing");
  c_packet: cover property (@(posedge aclk) disable iff (!aresetn) ev.packet_ok ##1 !irq_n);
  c_clear: cover property (@(posedge aclk) disable iff (!aresetn) ev_clear ##1 irq_n);
  c_idle: cover property (@(posedge aclk) disable iff (!aresetn) $rose(rx_idle_q));

endmodule

// [verilog/hls_pkg.sv]
// hls_pkg: register map, field positions and reset values of the link status flag bank
// assumes an axi4-lite master with 32-bit data; registers sit in the low byte of a word
package hls_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [3:0] SEQ_STATUS_ADDR   = 4'h0;
  localparam logic [3:0] EVENT_STATUS_ADDR = 4'h4;
  localparam logic [3:0] LINE_STATUS_ADDR  = 4'h8;
  localparam logic [3:0] LINK_CTRL_ADDR    = 4'hC;

  // ==========================================================================
  // field positions
  localparam int SEQ_NOT_READY_SENT = 0;
  localparam int SEQ_NEXT_TX_LSB    = 1;
  localparam int EV_NEXT_EXP_LSB    = 1;
  localparam int EV_ERROR           = 5;
  localparam int EV_ACKED           = 6;
  localparam int EV_PACKET          = 7;
  localparam int LN_LINK_N          = 0;
  localparam int LN_WRONG_ADDR      = 1;
  localparam int LN_RX_IDLE         = 5;
  localparam int LN_INT_RTS         = 6;
  localparam int LN_TIMEOUT         = 7;
  localparam int CTL_RX_READY       = 0;

  // ==========================================================================
  // reset values and counts
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam int         IDLE_ONES_MIN  = 15;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ==========================================================================
  // link-side events, one-cycle pulses from the frame engine
  typedef struct packed {
    logic       packet_ok;
    logic       acked;
    logic [2:0] acked_count;
    logic       fatal_error;
    logic       link_change;
    logic       chain_next;
    logic       dir_reset;
    logic       not_ready_tx;
    logic       addr_wrong;
    logic       addr_match;
    logic       timer_expired;
    logic       timer_restart;
    logic       tx_advance;
  } hls_events_s;

  typedef enum logic [2:0] {
    HLS_RD_IDLE = 3'b001,
    HLS_RD_RESP = 3'b010,
    HLS_RD_HOLD = 3'b100
  } hls_rd_e;

endpackage
